/* File: piebk_pkg.sv */
// Constants and helpers for the peripheral interrupt enable bank
package piebk_pkg;

    // -----------------------------------------------------------
    // Register map (byte addresses)
    // -----------------------------------------------------------
    localparam int          ADDR_W       = 5;
    localparam logic [4:0]  OFF_ENABLE_A = 5'h00;
    localparam logic [4:0]  OFF_ENABLE_B = 5'h04;
    localparam logic [4:0]  OFF_ENABLE_C = 5'h08;
    localparam logic [4:0]  OFF_CONTROL  = 5'h0C;
    localparam logic [4:0]  OFF_FLAGS_A  = 5'h10;
    localparam logic [4:0]  OFF_FLAGS_B  = 5'h14;
    localparam logic [4:0]  OFF_FLAGS_C  = 5'h18;

    // -----------------------------------------------------------
    // Field layout and reset values
    // -----------------------------------------------------------
    localparam int          GRP_W        = 8;
    localparam logic [7:0]  IMPL_A       = 8'hFF;
    localparam logic [7:0]  IMPL_B       = 8'hEF;
    localparam logic [7:0]  IMPL_C       = 8'h7F;
    localparam logic [7:0]  ENABLE_RST   = 8'h00;
    localparam logic [7:0]  FLAGS_RST    = 8'h00;
    localparam int          CTL_GLOBAL   = 7;
    localparam int          CTL_PERIPH   = 6;
    localparam logic [7:0]  CTL_MASK     = 8'hC0;
    localparam logic [7:0]  CTL_RST      = 8'h00;
    localparam int          BIT_TMR1_GATE = 7;
    localparam int          BIT_UNIMPL_B  = 4;
    localparam int          BIT_UNIMPL_C  = 7;
    localparam logic [31:0] RDATA_NONE   = 32'h0000_0000;

    // Address match on the word, byte lane bits ignored
    function automatic logic piebk_sel(input logic [4:0] addr,
                                       input logic [4:0] off);
        return addr[4:2] == off[4:2];
    endfunction : piebk_sel

endpackage : piebk_pkg

/* File: piebk_group.sv */
// One 8-bit group: enable register, sticky flags, group request
module piebk_group
    import piebk_pkg::*;
#(
    parameter int         W    = GRP_W,
    parameter logic [7:0] IMPL = IMPL_A
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic         i_en_we,
    input  wire logic         i_flag_w1c,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic [W-1:0] i_event,
    output logic      [W-1:0] o_enable,
    output logic      [W-1:0] o_flags,
    output logic              o_req
);

    logic [W-1:0] enable_r;
    logic [W-1:0] enable_nxt;
    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;
    logic [W-1:0] clr_mask;

    // Unimplemented bits never store a one
    assign enable_nxt = i_en_we ? (i_wdata & IMPL[W-1:0]) : enable_r;
    // Set beats a simultaneous write-one-to-clear
    assign clr_mask   = i_flag_w1c ? i_wdata : '0;
    assign flags_nxt  = ((flags_r & ~clr_mask) | i_event)
                        & IMPL[W-1:0];

    // Enable and flag storage, cleared on every reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            enable_r <= ENABLE_RST[W-1:0];
            flags_r  <= FLAGS_RST[W-1:0];
        end else if (i_ce) begin
            enable_r <= enable_nxt;
            flags_r  <= flags_nxt;
        end
    end

    assign o_enable = enable_r;
    assign o_flags  = flags_r;
    assign o_req    = |(flags_r & enable_r);

endmodule : piebk_group

/* File: piebk_top.sv */
// Peripheral interrupt enable bank with Avalon-MM register slave
//
// Design decisions made here: the address map and the Avalon-MM slave port.
module piebk_top
    import piebk_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [3:0]        i_avs_byteenable,
    input  wire logic [31:0]       i_avs_writedata,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic [7:0]        i_event_a,
    input  wire logic [7:0]        i_event_b,
    input  wire logic [7:0]        i_event_c,
    output logic                   o_periph_req,
    output logic                   o_irq
);

    // -----------------------------------------------------------
    // Bus handshake
    // -----------------------------------------------------------
    logic        ack_r;
    logic        ack_nxt;
    logic        req;
    logic        wr_acc;
    logic        lane0;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // One wait cycle, then the access completes; held off while frozen
    assign req               = i_avs_read | i_avs_write;
    assign ack_nxt           = req & ~ack_r;
    assign o_avs_waitrequest = req & ~(ack_r & i_ce);
    assign wr_acc            = i_avs_write & ack_r & i_ce;
    assign lane0             = i_avs_byteenable[0];

    // -----------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------
    logic sel_en_a;
    logic sel_en_b;
    logic sel_en_c;
    logic sel_ctl;
    logic sel_fl_a;
    logic sel_fl_b;
    logic sel_fl_c;

    // Register selects
    assign sel_en_a = piebk_sel(i_avs_address, OFF_ENABLE_A);
    assign sel_en_b = piebk_sel(i_avs_address, OFF_ENABLE_B);
    assign sel_en_c = piebk_sel(i_avs_address, OFF_ENABLE_C);
    assign sel_ctl  = piebk_sel(i_avs_address, OFF_CONTROL);
    assign sel_fl_a = piebk_sel(i_avs_address, OFF_FLAGS_A);
    assign sel_fl_b = piebk_sel(i_avs_address, OFF_FLAGS_B);
    assign sel_fl_c = piebk_sel(i_avs_address, OFF_FLAGS_C);

    // Write strobes, low byte lane only
    logic we_en_a;
    logic we_en_b;
    logic we_en_c;
    logic we_ctl;
    logic w1c_a;
    logic w1c_b;
    logic w1c_c;

    assign we_en_a = wr_acc & lane0 & sel_en_a;
    assign we_en_b = wr_acc & lane0 & sel_en_b;
    assign we_en_c = wr_acc & lane0 & sel_en_c;
    assign we_ctl  = wr_acc & lane0 & sel_ctl;
    assign w1c_a   = wr_acc & lane0 & sel_fl_a;
    assign w1c_b   = wr_acc & lane0 & sel_fl_b;
    assign w1c_c   = wr_acc & lane0 & sel_fl_c;

    // -----------------------------------------------------------
    // Core control: global and peripheral-group enables
    // -----------------------------------------------------------
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic       global_irq_enable;
    logic       peripheral_group_enable;

    assign ctl_nxt = we_ctl ? (i_avs_writedata[7:0] & CTL_MASK) : ctl_r;
    assign global_irq_enable       = ctl_r[CTL_GLOBAL];
    assign peripheral_group_enable = ctl_r[CTL_PERIPH];

    // -----------------------------------------------------------
    // Enable groups
    // -----------------------------------------------------------
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] en_c;
    logic [7:0] fl_a;
    logic [7:0] fl_b;
    logic [7:0] fl_c;
    logic       req_a;
    logic       req_b;
    logic       req_c;

    // Group A: timer gate, converter, serial, capcomp, timers
    piebk_group #(.W(GRP_W), .IMPL(IMPL_A)) u_grp_a (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_en_we    (we_en_a),
        .i_flag_w1c (w1c_a),
        .i_wdata    (i_avs_writedata[7:0]),
        .i_event    (i_event_a),
        .o_enable   (en_a),
        .o_flags    (fl_a),
        .o_req      (req_a)
    );

    // Group B: osc fail, comparators, collision, timers, capcomp
    piebk_group #(.W(GRP_W), .IMPL(IMPL_B)) u_grp_b (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_en_we    (we_en_b),
        .i_flag_w1c (w1c_b),
        .i_wdata    (i_avs_writedata[7:0]),
        .i_event    (i_event_b),
        .o_enable   (en_b),
        .o_flags    (fl_b),
        .o_req      (req_b)
    );

    // Group C: synthesiser, shutdown, zero cross, logic cells
    piebk_group #(.W(GRP_W), .IMPL(IMPL_C)) u_grp_c (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_en_we    (we_en_c),
        .i_flag_w1c (w1c_c),
        .i_wdata    (i_avs_writedata[7:0]),
        .i_event    (i_event_c),
        .o_enable   (en_c),
        .o_flags    (fl_c),
        .o_req      (req_c)
    );

    // -----------------------------------------------------------
    // Request gating
    // -----------------------------------------------------------
    logic periph_nxt;
    logic irq_nxt;
    logic periph_r;
    logic irq_r;

    // Group enable gates all, global enable gates the core line
    assign periph_nxt = (req_a | req_b | req_c)
                        & peripheral_group_enable;
    assign irq_nxt    = periph_nxt & global_irq_enable;

    // -----------------------------------------------------------
    // Read mux
    // -----------------------------------------------------------
    assign rdata_nxt =
        sel_en_a ? {24'h00_0000, en_a}  :
        sel_en_b ? {24'h00_0000, en_b}  :
        sel_en_c ? {24'h00_0000, en_c}  :
        sel_ctl  ? {24'h00_0000, ctl_r} :
        sel_fl_a ? {24'h00_0000, fl_a}  :
        sel_fl_b ? {24'h00_0000, fl_b}  :
        sel_fl_c ? {24'h00_0000, fl_c}  : RDATA_NONE;

    // Bus state, control register and registered outputs
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ack_r    <= 1'b0;
            rdata_r  <= RDATA_NONE;
            ctl_r    <= CTL_RST;
            periph_r <= 1'b0;
            irq_r    <= 1'b0;
        end else if (i_ce) begin
            ack_r    <= ack_nxt;
            if (i_avs_read && !ack_r) begin
                rdata_r <= rdata_nxt;
            end
            ctl_r    <= ctl_nxt;
            periph_r <= periph_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign o_avs_readdata = rdata_r;
    assign o_periph_req   = periph_r;
    assign o_irq          = irq_r;

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    sequence s_wr_a;
        i_ce && wr_acc && sel_en_a && lane0;
    endsequence

    sequence s_wr_b;
        i_ce && wr_acc && sel_en_b && lane0;
    endsequence

    sequence s_wr_c;
        i_ce && wr_acc && sel_en_c && lane0;
    endsequence

    property p_bit7_a_admits;
        @(posedge i_clock) disable iff (i_rst)
        i_ce && fl_a[BIT_TMR1_GATE] && en_a[BIT_TMR1_GATE]
            && peripheral_group_enable |=> o_periph_req;
    endproperty
    a_bit7_a_admits: assert property (p_bit7_a_admits)
        else $error("timer gate request not raised");

    property p_en_a_write;
        @(posedge i_clock) disable iff (i_rst)
        s_wr_a |=> en_a == $past(i_avs_writedata[7:0]);
    endproperty
    a_en_a_write: assert property (p_en_a_write)
        else $error("enable A write not stored");

    property p_en_b_write;
        @(posedge i_clock) disable iff (i_rst)
        s_wr_b |=> en_b == ($past(i_avs_writedata[7:0]) & IMPL_B);
    endproperty
    a_en_b_write: assert property (p_en_b_write)
        else $error("enable B write not stored");

    property p_unimpl_b;
        @(posedge i_clock) disable iff (i_rst)
        en_b[BIT_UNIMPL_B] == 1'b0;
    endproperty
    a_unimpl_b: assert property (p_unimpl_b)
        else $error("enable B bit 4 set");

    property p_unimpl_c;
        @(posedge i_clock) disable iff (i_rst)
        s_wr_c |=> !en_c[BIT_UNIMPL_C] && !fl_c[BIT_UNIMPL_C];
    endproperty
    a_unimpl_c: assert property (p_unimpl_c)
        else $error("enable C bit 7 set");

    property p_en_c_write;
        @(posedge i_clock) disable iff (i_rst)
        s_wr_c |=> en_c[3:0] == $past(i_avs_writedata[3:0]);
    endproperty
    a_en_c_write: assert property (p_en_c_write)
        else $error("logic cell enables not stored");

    property p_group_block;
        @(posedge i_clock) disable iff (i_rst)
        i_ce && !peripheral_group_enable |=> !o_periph_req;
    endproperty
    a_group_block: assert property (p_group_block)
        else $error("request without group enable");

    property p_reset_clear;
        @(posedge i_clock)
        $fell(i_rst) |-> en_a == 8'h00 && en_b == 8'h00
            && en_c == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("enables not cleared by reset");

    property p_flag_set;
        @(posedge i_clock) disable iff (i_rst)
        i_ce && i_event_a != 8'h00
            |=> (fl_a & $past(i_event_a)) == $past(i_event_a);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set by event");

    property p_global_hold;
        @(posedge i_clock) disable iff (i_rst)
        i_ce && !global_irq_enable |-> ##1 !o_irq;
    endproperty
    a_global_hold: assert property (p_global_hold)
        else $error("irq while global enable clear");

    property p_pending_served;
        @(posedge i_clock) disable iff (i_rst)
        i_ce && periph_nxt && global_irq_enable |=> o_irq;
    endproperty
    a_pending_served: assert property (p_pending_served)
        else $error("pending request not delivered");

    property p_or_gate;
        @(posedge i_clock) disable iff (i_rst)
        i_ce |=> o_periph_req == $past(peripheral_group_enable
            && ((fl_a & en_a) != 8'h00 || (fl_b & en_b) != 8'h00
                || (fl_c & en_c) != 8'h00));
    endproperty
    a_or_gate: assert property (p_or_gate)
        else $error("request is not gated OR");

    property p_bus_answer;
        @(posedge i_clock) disable iff (i_rst)
        req && i_ce && !ack_r ##1 i_ce |-> !o_avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("waitrequest held past one cycle");

    // A frozen block must not let an access complete
    property p_bus_freeze;
        @(posedge i_clock) disable iff (i_rst)
        req && !i_ce |-> o_avs_waitrequest;
    endproperty
    a_bus_freeze: assert property (p_bus_freeze)
        else $error("access completed while clock enable low");

endmodule : piebk_top

/* File: piebk_src_model.sv */
// Peripheral event source model: one-cycle event pulses on request
module piebk_src_model (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic [23:0] i_fire,
    output logic      [23:0] o_event
);
    timeunit 1ns;
    timeprecision 1ps;

    // Registered pulse, low whenever nothing is requested
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_event <= 24'h000000;
        end else begin
            o_event <= i_fire;
        end
    end
endmodule : piebk_src_model

/* File: peripheral_irq_enable_bank_tb.sv */
// Self-checking testbench for the peripheral interrupt enable bank
module peripheral_irq_enable_bank_tb
    import piebk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clock;
    logic        i_rst;
    logic        ce;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [3:0]  be;
    logic [31:0] avs_writedata;
    logic [31:0] avs_rdata;
    logic        avs_wait;
    logic [23:0] ev_req;
    logic [23:0] ev;
    logic        o_periph_req;
    logic        o_irq;
    int          failures;
    int          comparisons;

    piebk_top dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_ce(ce),
        .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_byteenable(be),
        .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_rdata),
        .o_avs_waitrequest(avs_wait), .i_event_a(ev[7:0]),
        .i_event_b(ev[15:8]), .i_event_c(ev[23:16]),
        .o_periph_req(o_periph_req), .o_irq(o_irq)
    );

    piebk_src_model src (
        .i_clock(i_clock), .i_rst(i_rst), .i_fire(ev_req), .o_event(ev)
    );

    // Free-running clock
    always #5 i_clock = ~i_clock;

    // ----------
    // Helpers
    // ----------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Avalon access: hold until waitrequest sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_read <= ~w;
        avs_write <= w;
        do begin
            @(posedge i_clock);
        end while (avs_wait !== 1'h0);
        q = avs_rdata[7:0];
        if (w == 1'h0) begin
            chk(32'(avs_rdata[31:8]), 32'h00000000);
        end
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge i_clock);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'h1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'h0, a, 8'h00, q);
        chk(q, e);
    endtask : rd_chk

    // Pulse sources, then let flag and request registers settle
    task automatic fire(input logic [23:0] v);
        ev_req <= v;
        @(posedge i_clock);
        ev_req <= 24'h000000;
        repeat (4) @(posedge i_clock);
    endtask : fire

    // ----------
    // Scenarios
    // ----------
    // Reset clears everything; unmapped word reads zero
    task automatic t_reset();
        i_rst <= 1'h1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'h0;
        @(posedge i_clock);
        for (int k = 0; k < 8; k++) begin
            rd_chk(5'(k * 4), 8'h00);
        end
        chk(o_irq, 1'h0);
    endtask : t_reset

    // Read back, reserved bits and byte-enable masking
    task automatic t_rw();
        wr(OFF_ENABLE_A, 8'hFF);
        wr(OFF_ENABLE_B, 8'hFF);
        wr(OFF_ENABLE_C, 8'hFF);
        rd_chk(OFF_ENABLE_A, 8'hFF);
        rd_chk(OFF_ENABLE_B, 8'hEF);
        rd_chk(OFF_ENABLE_C, 8'h7F);
        be <= 4'h0;
        wr(OFF_ENABLE_A, 8'h00);
        be <= 4'hF;
        rd_chk(OFF_ENABLE_A, 8'hFF);
        for (int g = 0; g < 3; g++) begin
            wr(5'(g * 4), 8'h00);
            rd_chk(5'(g * 4), 8'h00);
        end
    endtask : t_rw

    // Group and global gating, pending request survives
    task automatic t_gates();
        wr(OFF_CONTROL, 8'h80);
        wr(OFF_ENABLE_B, 8'hFF);
        fire(24'h000100);
        chk(o_periph_req, 1'h0);
        chk(o_irq, 1'h0);
        rd_chk(OFF_FLAGS_B, 8'h01);
        wr(OFF_CONTROL, 8'hC0);
        repeat (3) @(posedge i_clock);
        chk(o_periph_req, 1'h1);
        chk(o_irq, 1'h1);
        wr(OFF_CONTROL, 8'h40);
        repeat (3) @(posedge i_clock);
        chk(o_periph_req, 1'h1);
        chk(o_irq, 1'h0);
        wr(OFF_CONTROL, 8'hC0);
        repeat (3) @(posedge i_clock);
        chk(o_irq, 1'h1);
        wr(OFF_FLAGS_B, 8'h01);
        repeat (3) @(posedge i_clock);
        chk(o_periph_req, 1'h0);
        wr(OFF_ENABLE_B, 8'h00);
    endtask : t_gates

    // Each implemented enable bit admits its own source and no other
    task automatic t_bits();
        logic [7:0] m;
        logic [7:0] bm;
        logic [4:0] off;
        for (int g = 0; g < 3; g++) begin
            m = (g == 0) ? IMPL_A : (g == 1) ? IMPL_B : IMPL_C;
            off = 5'(g * 4);
            for (int b = 0; b < 8; b++) begin
                bm = 8'h01 << b;
                wr(off, bm);
                fire({16'h0000, ~bm} << (8 * g));
                chk(o_periph_req, 1'h0);
                fire({16'h0000, bm} << (8 * g));
                chk(o_periph_req, m[b]);
                chk(o_irq, m[b]);
                rd_chk(off + 5'h10, m);
                wr(off + 5'h10, 8'hFF);
            end
            wr(off, 8'h00);
        end
    endtask : t_bits

    // Clock enable low freezes flags, requests and the bus
    task automatic t_freeze();
        wr(OFF_ENABLE_A, 8'h01);
        ce <= 1'h0;
        fire(24'h000001);
        chk(o_periph_req, 1'h0);
        ce <= 1'h1;
        rd_chk(OFF_FLAGS_A, 8'h00);
        fire(24'h000001);
        chk(o_irq, 1'h1);
        ce <= 1'h0;
        avs_address <= OFF_ENABLE_A;
        avs_writedata <= 32'h00000000;
        avs_write <= 1'h1;
        repeat (3) @(posedge i_clock);
        chk(avs_wait, 1'h1);
        chk(o_irq, 1'h1);
        ce <= 1'h1;
        do begin
            @(posedge i_clock);
        end while (avs_wait !== 1'h0);
        avs_write <= 1'h0;
        @(posedge i_clock);
        rd_chk(OFF_ENABLE_A, 8'h00);
        chk(o_periph_req, 1'h0);
        wr(OFF_FLAGS_A, 8'hFF);
        rd_chk(OFF_FLAGS_A, 8'h00);
    endtask : t_freeze

    task automatic report_and_stop();
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial begin
        i_clock = 1'h0;
        i_rst = 1'h1;
        ce = 1'h1;
        avs_address = 5'h00;
        avs_read = 1'h0;
        avs_write = 1'h0;
        be = 4'hF;
        avs_writedata = 32'h00000000;
        ev_req = 24'h000000;
        failures = 0;
        comparisons = 0;
        t_reset();
        t_rw();
        t_gates();
        t_bits();
        t_freeze();
        wr(OFF_ENABLE_A, 8'hFF);
        wr(OFF_CONTROL, 8'hC0);
        t_reset();
        report_and_stop();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge i_clock);
        failures++;
        report_and_stop();
    end
endmodule : peripheral_irq_enable_bank_tb
